// ---- fpm_pkg.sv ----
// package for the fault pin mask unit: register map, fields, types
package fpm_pkg;

    localparam int unsigned FPM_NFLAG = 10;
    localparam logic [11:0] FPM_ADDR_MASK = 12'h048;
    localparam logic [11:0] FPM_ADDR_STATUS = 12'h000;
    localparam logic [11:0] FPM_ADDR_FLAGS = 12'h004;
    localparam logic [11:0] FPM_ADDR_IRQ_STAT = 12'h008;
    localparam logic [11:0] FPM_ADDR_IRQ_MASK = 12'h00c;
    localparam logic [21:0] FPM_MASK_RESET = 22'h120000;
    localparam logic [4:0] FPM_MASK_INDEX = 5'h12;
    localparam int unsigned FPM_PIN_BIT = 21;
    localparam int unsigned FPM_ADR_LSB = 16;
    localparam int unsigned FPM_ADR_MSB = 20;
    localparam logic [15:0] FPM_MASK_WR_BITS = 16'h97cd;
    localparam logic [31:0] FPM_ZERO_WORD = 32'h00000000;

    // mask bit position of each fault flag, flag index order
    localparam int unsigned FPM_POS_DIE_TEMP = 0;
    localparam int unsigned FPM_POS_VSHORT = 2;
    localparam int unsigned FPM_POS_IOPEN = 3;
    localparam int unsigned FPM_POS_CRC = 6;
    localparam int unsigned FPM_POS_SLIP = 7;
    localparam int unsigned FPM_POS_WDOG = 8;
    localparam int unsigned FPM_POS_LATCH = 9;
    localparam int unsigned FPM_POS_CLKHALT = 10;
    localparam int unsigned FPM_POS_INVCHK = 12;
    localparam int unsigned FPM_POS_SERIAL = 15;

    typedef struct packed {
        logic serial_access;
        logic inverse_converter_check;
        logic clock_halt;
        logic converter_latch_monitor;
        logic watchdog_timeout;
        logic frame_slip;
        logic serial_crc;
        logic current_open_circuit;
        logic voltage_short;
        logic die_temp;
    } fpm_flags_t;

    typedef struct packed {
        logic [11:0] addr;
        logic write;
        logic [31:0] wdata;
        logic [3:0] strb;
    } fpm_req_t;

endpackage

// ---- fpm_gate.sv ----
// per-flag mask gating and fault pin reduction
`timescale 1ns/1ps
module fpm_gate
    import fpm_pkg::*;
(
    input wire fpm_flags_t flags,
    input wire logic [15:0] mask,
    output logic fault_any
);
    logic [FPM_NFLAG-1:0] pass;
    logic [FPM_NFLAG-1:0] fvec;

    function automatic int unsigned fpm_pos(input int unsigned i);
        unique case (i)
            0: fpm_pos = FPM_POS_DIE_TEMP;
            1: fpm_pos = FPM_POS_VSHORT;
            2: fpm_pos = FPM_POS_IOPEN;
            3: fpm_pos = FPM_POS_CRC;
            4: fpm_pos = FPM_POS_SLIP;
            5: fpm_pos = FPM_POS_WDOG;
            6: fpm_pos = FPM_POS_LATCH;
            7: fpm_pos = FPM_POS_CLKHALT;
            8: fpm_pos = FPM_POS_INVCHK;
            default: fpm_pos = FPM_POS_SERIAL;
        endcase
    endfunction

    assign fvec = flags;

    // masking only blocks the path, the flag itself is untouched
    for (genvar i = 0; i < FPM_NFLAG; i++) begin : g_pass
        assign pass[i] = fvec[i] & ~mask[fpm_pos(i)];
    end

    assign fault_any = |pass;
endmodule

// ---- fpm_top.sv ----
// fault pin mask unit: apb registers, fault pin and interrupt
`timescale 1ns/1ps
//
// Contract
// - mask register bit 21 reads back the inverse of the live fault pin level, 1 while the pin is low
// - mask register at index 0x12, resets to 0x120000, masks clear
// - mask bit 15 blocks the invalid serial access flag
// - mask bit 12 blocks the inverse converter check flag
// - mask bit 10 blocks the oscillator stop flag
// - mask bit 9 blocks the converter latch monitor flag
// - mask bit 8 blocks the watchdog timeout flag
// - mask bit 7 blocks the frame slip flag
// - mask bit 6 blocks the serial crc flag
// - mask bit 3 blocks the current output open circuit flag
// - mask bit 2 blocks the voltage output short flag
// - mask bit 0 blocks the die over-temperature flag
module fpm_top
    import fpm_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clk_en,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire fpm_flags_t fault_flags,
    output logic fault_n,
    output logic irq
);
    logic [15:0] mask_reg, mask_next;
    logic fault_reg, fault_next;
    logic fault_n_reg, fault_n_next;
    logic [31:0] prdata_reg, prdata_next;
    logic pready_reg, pready_next;
    logic pslverr_reg, pslverr_next;
    logic [FPM_NFLAG-1:0] istat_reg, istat_next;
    logic [FPM_NFLAG-1:0] imask_reg, imask_next;
    logic [FPM_NFLAG-1:0] flags_d_reg, flags_d_next;
    logic irq_reg, irq_next;
    logic fault_any;
    logic setup;
    fpm_req_t req;

    function automatic logic addr_ok(input logic [11:0] a);
        addr_ok = (a == FPM_ADDR_MASK) || (a == FPM_ADDR_STATUS) ||
            (a == FPM_ADDR_FLAGS) || (a == FPM_ADDR_IRQ_STAT) ||
            (a == FPM_ADDR_IRQ_MASK);
    endfunction

    function automatic logic [31:0] lane_merge(input logic [31:0] old,
        input logic [31:0] wd, input logic [3:0] st);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (st[b]) begin
                r[b*8 +: 8] = wd[b*8 +: 8];
            end
        end
        lane_merge = r;
    endfunction

    fpm_gate u_gate (
        .flags(fault_flags),
        .mask(mask_reg),
        .fault_any(fault_any)
    );

    assign req = '{addr: paddr, write: pwrite, wdata: pwdata, strb: pstrb};
    // slave answers in the setup cycle's following access cycle
    assign setup = psel & ~penable;

    always_comb begin
        logic [31:0] merged;
        logic [FPM_NFLAG-1:0] rise;
        logic [FPM_NFLAG-1:0] clr;
        merged = FPM_ZERO_WORD;
        rise = fault_flags & ~flags_d_reg;
        clr = '0;
        mask_next = mask_reg;
        imask_next = imask_reg;
        prdata_next = prdata_reg;
        pready_next = 1'b0;
        pslverr_next = 1'b0;
        fault_next = fault_any;
        // pin has its own flop so the port is a register output
        fault_n_next = ~fault_any;
        flags_d_next = fault_flags;
        if (setup) begin
            pready_next = 1'b1;
            pslverr_next = ~addr_ok(req.addr);
            prdata_next = FPM_ZERO_WORD;
            if (req.write) begin
                unique case (req.addr)
                    FPM_ADDR_MASK: begin
                        merged = lane_merge({16'h0000, mask_reg},
                            req.wdata, req.strb);
                        // reserved bits stay writable storage
                        mask_next = merged[15:0];
                    end
                    FPM_ADDR_IRQ_MASK: begin
                        merged = lane_merge({22'h000000, imask_reg},
                            req.wdata, req.strb);
                        imask_next = merged[FPM_NFLAG-1:0];
                    end
                    FPM_ADDR_IRQ_STAT: begin
                        merged = lane_merge(FPM_ZERO_WORD, req.wdata,
                            req.strb);
                        clr = merged[FPM_NFLAG-1:0];
                    end
                    default: begin
                        merged = FPM_ZERO_WORD;
                    end
                endcase
            end else begin
                unique case (req.addr)
                    FPM_ADDR_MASK: begin
                        prdata_next = {10'h000, fault_reg, FPM_MASK_INDEX,
                            mask_reg};
                    end
                    FPM_ADDR_STATUS: begin
                        prdata_next = {31'h00000000, fault_reg};
                    end
                    FPM_ADDR_FLAGS: begin
                        prdata_next = {22'h000000, fault_flags};
                    end
                    FPM_ADDR_IRQ_STAT: begin
                        prdata_next = {22'h000000, istat_reg};
                    end
                    FPM_ADDR_IRQ_MASK: begin
                        prdata_next = {22'h000000, imask_reg};
                    end
                    default: begin
                        prdata_next = FPM_ZERO_WORD;
                    end
                endcase
            end
        end
        // a new rising flag wins over a clear in the same cycle
        istat_next = (istat_reg & ~clr) | rise;
        irq_next = |(istat_next & ~imask_reg);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mask_reg <= FPM_MASK_RESET[15:0];
            imask_reg <= '0;
            istat_reg <= '0;
            flags_d_reg <= '0;
            fault_reg <= 1'b0;
            fault_n_reg <= 1'b1;
            prdata_reg <= FPM_ZERO_WORD;
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
            irq_reg <= 1'b0;
        end else if (clk_en) begin
            mask_reg <= mask_next & FPM_MASK_WR_BITS | mask_next &
                ~FPM_MASK_WR_BITS;
            imask_reg <= imask_next;
            istat_reg <= istat_next;
            flags_d_reg <= flags_d_next;
            fault_reg <= fault_next;
            fault_n_reg <= fault_n_next;
            prdata_reg <= prdata_next;
            pready_reg <= pready_next;
            pslverr_reg <= pslverr_next;
            irq_reg <= irq_next;
        end
    end

    // pin is active low; status bit reports the inverse of the pin level, 1 while the pin is low
    assign fault_n = fault_n_reg;
    assign prdata = prdata_reg;
    assign pready = pready_reg;
    assign pslverr = pslverr_reg;
    assign irq = irq_reg;
endmodule

// ---- fpm_props.sv ----
// port assertions for the fault pin mask unit
`timescale 1ns/1ps
module fpm_props
    import fpm_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clk_en,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire fpm_flags_t fault_flags,
    input wire logic fault_n,
    input wire logic irq
);
    wire logic rd_mask = pready && !pslverr && !pwrite &&
        paddr == FPM_ADDR_MASK;
    default clocking @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    a_pin_idle: assert property (clk_en && fault_flags == '0 |=> fault_n)
        else $error("fault pin low with no flag");
    a_ready_pulse: assert property (clk_en && psel && !penable |=> pready)
        else $error("no answer in access cycle");
    a_ready_once: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    a_idle_quiet: assert property (clk_en && !psel |=> !pready)
        else $error("pready without request");
    a_err_pairs: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    a_err_zero: assert property (pslverr |-> prdata == '0)
        else $error("refused read returned data");
    // pin bit only judged while the pin holds still, capture edge is open
    a_pin_readback: assert property (
        rd_mask && $stable(fault_n) |-> prdata[21] == !fault_n)
        else $error("pin status bit wrong");
    a_addr_field: assert property (
        rd_mask |-> prdata[20:16] == FPM_MASK_INDEX)
        else $error("address field wrong");
    cover property ($fell(fault_n));
    cover property (pslverr);
    cover property ($rose(irq));
endmodule
bind fpm_top fpm_props u_props (.pclk, .presetn, .clk_en, .psel, .penable,
    .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr,
    .fault_flags, .fault_n, .irq);

// ---- fpm_host_mon.sv ----
// host controller model watching the fault pin
`timescale 1ns/1ps
module fpm_host_mon (
    input wire logic pclk,
    input wire logic fault_n,
    output logic alarm
);
    // one sampling flop, as a host input stage would add
    always_ff @(posedge pclk) begin
        alarm <= !fault_n;
    end
endmodule

// ---- tb_top.sv ----
// self-checking bench for the fault pin mask unit
`timescale 1ns/1ps
module tb_top;
    import fpm_pkg::*;
    logic pclk = 0, presetn = 0, clk_en = 1, psel = 0, penable = 0, pwrite = 0;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata;
    logic [3:0] pstrb = 4'hf;
    logic pready, pslverr, fault_n, irq, alarm;
    fpm_flags_t fault_flags = '0;
    int bad_count = 0, n_compared = 0;
    logic [64:0] q[$];
    int unsigned pos[10] = '{FPM_POS_DIE_TEMP, FPM_POS_VSHORT, FPM_POS_IOPEN,
        FPM_POS_CRC, FPM_POS_SLIP, FPM_POS_WDOG, FPM_POS_LATCH,
        FPM_POS_CLKHALT, FPM_POS_INVCHK, FPM_POS_SERIAL};
    fpm_top DUT (.pclk, .presetn, .clk_en, .psel, .penable, .pwrite, .paddr,
        .pwdata, .pstrb, .prdata, .pready, .pslverr, .fault_flags, .fault_n,
        .irq);
    fpm_host_mon u_host (.pclk, .fault_n, .alarm);
    always #2 pclk = ~pclk;
    task final_report;
        $display("compared %0d mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task chk(string n, logic [31:0] e, logic [31:0] s);
        n_compared++;
        if (e !== s) begin
            bad_count++;
            $display("Error %s expected %h seen %h", n, e, s);
        end
    endtask
    // e holds expected pslverr, compare mask and data
    task apb(logic w, logic [11:0] a, logic [31:0] d, logic [64:0] e);
        int k;
        q.push_back(e);
        @(posedge pclk);
        psel <= 1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        k = 0;
        do @(posedge pclk); while (pready !== 1'b1 && ++k < 20);
        if (k == 20) begin
            bad_count++;
            final_report;
        end
        psel <= 0;
        penable <= 0;
    endtask
    function logic pin(logic [9:0] f, logic [15:0] m);
        pin = 0;
        for (int i = 0; i < 10; i++)
            pin |= f[i] & !m[pos[i]];
    endfunction
    always @(posedge pclk) begin
        logic [64:0] e;
        if (presetn && pready === 1'b1) begin
            e = q.pop_front();
            chk("pslverr", 32'(e[64]), 32'(pslverr));
            chk("prdata", e[31:0], prdata & e[63:32]);
        end
    end
    initial begin
        logic [15:0] m;
        logic [9:0] f;
        logic p;
        void'($urandom(6));
        repeat (8) @(posedge pclk);
        presetn <= 1;
        apb(0, FPM_ADDR_MASK, 0, {1'b0, 32'hffffffff, 32'h00120000});
        for (int i = 0; i < 16; i++) begin
            // reserved mask bits kept zero by the host
            f = (i < 10) ? 10'(1 << i) : 10'($urandom);
            m = (i < 10) ? 16'(1 << pos[i]) :
                16'($urandom) & FPM_MASK_WR_BITS;
            fault_flags <= f;
            repeat (3) @(posedge pclk);
            chk("alarm", 32'(pin(f, 0)), 32'(alarm));
            chk("irq", 32'(f != 0), 32'(irq));
            apb(1, FPM_ADDR_MASK, 32'(m), '0);
            repeat (3) @(posedge pclk);
            p = pin(f, m);
            chk("alarm", 32'(p), 32'(alarm));
            apb(0, FPM_ADDR_MASK, 0, {1'b0, 32'hffffffff, 10'h0, p, 5'h12, m});
            apb(0, FPM_ADDR_FLAGS, 0, {1'b0, 32'h3ff, 22'h0, f});
            fault_flags <= '0;
            apb(1, FPM_ADDR_MASK, 0, '0);
            apb(1, FPM_ADDR_IRQ_STAT, 32'h3ff, '0);
            repeat (2) @(posedge pclk);
            chk("irq", 0, 32'(irq));
        end
        apb(1, FPM_ADDR_IRQ_MASK, 32'h3ff, '0);
        fault_flags <= 10'h001;
        repeat (3) @(posedge pclk);
        chk("irq", 0, 32'(irq));
        apb(0, FPM_ADDR_IRQ_STAT, 0, {1'b0, 32'h3ff, 32'h1});
        apb(1, FPM_ADDR_IRQ_MASK, 0, '0);
        repeat (2) @(posedge pclk);
        chk("irq", 1, 32'(irq));
        apb(1, FPM_ADDR_IRQ_STAT, 32'h1, '0);
        repeat (2) @(posedge pclk);
        chk("irq", 0, 32'(irq));
        // enable low must freeze the pin while the flag drops
        clk_en <= 0;
        fault_flags <= '0;
        repeat (3) @(posedge pclk);
        chk("alarm", 1, 32'(alarm));
        clk_en <= 1;
        repeat (3) @(posedge pclk);
        chk("alarm", 0, 32'(alarm));
        apb(0, 12'hffc, 0, {1'b1, 32'hffffffff, 32'h0});
        apb(1, 12'hff8, 32'h5, {1'b1, 64'h0});
        repeat (2) @(posedge pclk);
        final_report;
    end
endmodule
